// >>> inc/pst_defs.vh
// constants for the program space table access block
// assumes a 24-bit program word store and a 16-bit data path
`ifndef PST_DEFS_VH
`define PST_DEFS_VH

// -----------------------------------------------------------------
// widths
// -----------------------------------------------------------------
`define PST_PW          24
`define PST_DW          16
`define PST_AW          8
`define PST_MEM_AW      8
`define PST_MEM_DEPTH   256

// -----------------------------------------------------------------
// register offsets (byte addresses)
// -----------------------------------------------------------------
`define OFS_PAGE        8'h00
`define OFS_EA          8'h04
`define OFS_WDATA       8'h08
`define OFS_CMD         8'h0C
`define OFS_RESULT      8'h10
`define OFS_STATUS      8'h14
`define OFS_PADDR       8'h18
`define OFS_PC          8'h1C
`define OFS_PC_STEP     8'h20
`define OFS_WIN_PAGE    8'h24

// -----------------------------------------------------------------
// command field layout and operation codes
// -----------------------------------------------------------------
`define CMD_OP_HI       2
`define CMD_OP_LO       0
`define CMD_BYTE_BIT    3
`define OP_READ_LOW     3'h0
`define OP_READ_HIGH    3'h1
`define OP_WRITE_LOW    3'h2
`define OP_WRITE_HIGH   3'h3
`define OP_WIN_READ     3'h4

// -----------------------------------------------------------------
// status bits
// -----------------------------------------------------------------
`define ST_DONE_BIT     0
`define ST_BUSY_BIT     1
`define ST_CFG_BIT      2

// -----------------------------------------------------------------
// reset values and steps
// -----------------------------------------------------------------
`define RST_PAGE        8'h00
`define RST_PC          24'h000000
`define PC_INC          24'h000002
`define PAGE_CFG_BIT    7

`endif

// >>> logic/prog_word_mem.v
// program word store: 24-bit words, three byte lanes
// assumes one clock, a freezing clock enable, registered read data
`timescale 1ns/1ps
`default_nettype none
`include "pst_defs.vh"

module prog_word_mem (
    // clock
    input  wire                    mclk,
    input  wire                    ce,
    // access port
    input  wire                    en,
    input  wire [2:0]              lane_we,
    input  wire [`PST_MEM_AW-1:0]  addr,
    input  wire [`PST_PW-1:0]      wdata,
    output reg  [`PST_PW-1:0]      rdata
);

    reg [`PST_PW-1:0] mem [0:`PST_MEM_DEPTH-1];
    integer           i;

    // -------------------------------------------------------------
    // lane writes and registered read
    // -------------------------------------------------------------
    always @(posedge mclk) begin
        if (ce && en) begin
            for (i = 0; i < 3; i = i + 1) begin
                if (lane_we[i]) begin
                    mem[addr][i*8 +: 8] <= wdata[i*8 +: 8];
                end
            end
            rdata <= mem[addr];
        end
    end

endmodule // prog_word_mem

`default_nettype wire

// >>> logic/program_space_table_access.v
// program space table access: 16-bit data view of 24-bit program words
// assumes a register master on mclk; reads answer one cycle later
//
// Notes on behaviour
// - program words 24 bits, data 16 bits
// - address is page byte above effective address
// - page top bit picks user or configuration
// - program address lsb held at zero
// - program counter advances two per word
// - word low read returns bits 15..0
// - byte low read picks byte by select
// - word high read zero-fills upper data byte
// - byte high read: phantom byte reads zero
// - any byte address, configuration reads allowed
// - low ops reach 15..0, high 23..16
// - read-only window shows low word only
`timescale 1ns/1ps
`default_nettype none
`include "pst_defs.vh"

module program_space_table_access (
    // clock and reset
    input  wire                  mclk,
    input  wire                  rst,
    input  wire                  ce,
    // register port
    input  wire [`PST_AW-1:0]    addr,
    input  wire [31:0]           wdata,
    input  wire                  wr,
    input  wire                  rd,
    output reg  [31:0]           rdata,
    // status
    output reg                   busy
);

    // -------------------------------------------------------------
    // states
    // -------------------------------------------------------------
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_ISSUE = 2'h1;
    localparam [1:0] ST_CAPT  = 2'h2;

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    // word index into the store: space bit and word bits, lsb dropped
    function [`PST_MEM_AW-1:0] word_index;
        input [`PST_PW-1:0] paddr;
        begin
            word_index = {paddr[`PST_PW-1], paddr[`PST_MEM_AW-1:1]};
        end
    endfunction

    // force the lsb of a program address to zero
    function [`PST_PW-1:0] align_addr;
        input [`PST_PW-1:0] a;
        begin
            align_addr = {a[`PST_PW-1:1], 1'b0};
        end
    endfunction

    // strobe aimed at one register offset
    function reg_hit;
        input       strobe;
        input [7:0] a;
        input [7:0] ofs;
        begin
            reg_hit = strobe && (a == ofs);
        end
    endfunction

    // ops that hand a value back through the result register
    function op_reads;
        input [2:0] o;
        begin
            op_reads = (o == `OP_READ_LOW) || (o == `OP_READ_HIGH) ||
                       (o == `OP_WIN_READ);
        end
    endfunction

    // one program word spans two data addresses; carry out is dropped
    function [`PST_PW-1:0] next_word_addr;
        input [`PST_PW-1:0] a;
        reg   [`PST_PW:0]   sum;
        begin
            sum            = {1'b0, a} + {1'b0, `PC_INC};
            next_word_addr = sum[`PST_PW-1:0];
        end
    endfunction

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    reg [7:0]            page_reg;
    reg [`PST_DW-1:0]    ea_reg;
    reg [`PST_DW-1:0]    wdat_reg;
    reg [3:0]            cmd_reg;
    reg [`PST_DW-1:0]    result_reg;
    reg                  done_reg;
    reg                  cfg_reg;
    reg [`PST_PW-1:0]    paddr_reg;
    reg [`PST_PW-1:0]    pc_reg;
    reg [7:0]            win_page_reg;
    reg [1:0]            state_reg;
    reg [1:0]            state_next;

    wire [2:0]           op    = cmd_reg[`CMD_OP_HI:`CMD_OP_LO];
    wire                 bmode = cmd_reg[`CMD_BYTE_BIT];
    wire                 bsel  = ea_reg[0];
    wire                 start = reg_hit(wr, addr, `OFS_CMD) &&
                                 (state_reg == ST_IDLE);

    // -------------------------------------------------------------
    // program address forming
    // -------------------------------------------------------------
    wire [`PST_PW-1:0]   tbl_addr;
    wire [`PST_PW-1:0]   win_addr;
    wire [`PST_PW-1:0]   cur_addr;
    wire                 is_win;

    // page byte above the effective address, lsb forced low
    assign tbl_addr = align_addr({page_reg, ea_reg});
    // window: page byte, then 15 bits of the data address
    assign win_addr = align_addr({win_page_reg, 1'b0,
                                  ea_reg[`PST_DW-2:0]});
    assign is_win   = (op == `OP_WIN_READ);
    assign cur_addr = is_win ? win_addr : tbl_addr;

    // -------------------------------------------------------------
    // store port drive
    // -------------------------------------------------------------
    reg                  mem_en;
    reg  [2:0]           mem_we;
    reg  [`PST_PW-1:0]   mem_wd;
    wire [`PST_PW-1:0]   mem_rd;

    always @* begin
        mem_en = (state_reg == ST_ISSUE);
        mem_we = 3'h0;
        mem_wd = {wdat_reg[7:0], wdat_reg};
        if (state_reg == ST_ISSUE) begin
            case (op)
                `OP_WRITE_LOW: begin
                    if (!bmode) begin
                        mem_we = 3'h3;
                    end else begin
                        // byte goes to the lane picked by select
                        mem_wd = {wdat_reg[7:0], wdat_reg[7:0],
                                  wdat_reg[7:0]};
                        mem_we = bsel ? 3'h2 : 3'h1;
                    end
                end
                `OP_WRITE_HIGH: begin
                    // phantom byte has no storage; write is dropped
                    mem_we = (bmode && bsel) ? 3'h0 : 3'h4;
                end
                default: begin
                    mem_we = 3'h0;
                end
            endcase
        end
    end

    // 24-bit program word store, 16-bit data view
    prog_word_mem u_store (
        .mclk    (mclk),
        .ce      (ce),
        .en      (mem_en),
        .lane_we (mem_we),
        .addr    (word_index(cur_addr)),
        .wdata   (mem_wd),
        .rdata   (mem_rd)
    );

    // -------------------------------------------------------------
    // result steering
    // -------------------------------------------------------------
    reg [`PST_DW-1:0]    read_val;

    always @* begin
        read_val = {`PST_DW{1'b0}};
        case (op)
            `OP_READ_LOW: begin
                if (!bmode) begin
                    read_val = mem_rd[15:0];
                end else if (bsel) begin
                    read_val = {8'h00, mem_rd[15:8]};
                end else begin
                    read_val = {8'h00, mem_rd[7:0]};
                end
            end
            `OP_READ_HIGH: begin
                if (bmode && bsel) begin
                    read_val = {`PST_DW{1'b0}};
                end else begin
                    // word and byte-select-0 both give bits 23..16
                    read_val = {8'h00, mem_rd[23:16]};
                end
            end
            `OP_WIN_READ: begin
                read_val = mem_rd[15:0];
            end
            default: begin
                read_val = {`PST_DW{1'b0}};
            end
        endcase
    end

    // -------------------------------------------------------------
    // access sequencer
    // -------------------------------------------------------------
    always @* begin
        case (state_reg)
            ST_IDLE: begin
                state_next = start ? ST_ISSUE : ST_IDLE;
            end
            ST_ISSUE: begin
                state_next = ST_CAPT;
            end
            ST_CAPT: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    wire finish = (state_reg == ST_CAPT);
    wire is_rd  = op_reads(op);

    always @(posedge mclk) begin
        if (rst) begin
            state_reg  <= ST_IDLE;
            result_reg <= {`PST_DW{1'b0}};
            paddr_reg  <= 24'h000000;
            cfg_reg    <= 1'b0;
            busy       <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            busy      <= (state_next != ST_IDLE);
            if (state_reg == ST_ISSUE) begin
                // no alignment check: any byte address is taken
                paddr_reg <= cur_addr;
                cfg_reg   <= cur_addr[`PST_PW-1];
            end
            if (finish && is_rd) begin
                result_reg <= read_val;
            end
        end
    end

    // -------------------------------------------------------------
    // software registers
    // -------------------------------------------------------------
    wire done_clr = reg_hit(wr, addr, `OFS_STATUS) &&
                    wdata[`ST_DONE_BIT];

    always @(posedge mclk) begin
        if (rst) begin
            page_reg     <= `RST_PAGE;
            ea_reg       <= 16'h0000;
            wdat_reg     <= 16'h0000;
            cmd_reg      <= 4'h0;
            done_reg     <= 1'b0;
            win_page_reg <= `RST_PAGE;
        end else if (ce) begin
            // set wins over a clear in the same cycle
            if (finish) begin
                done_reg <= 1'b1;
            end else if (done_clr) begin
                done_reg <= 1'b0;
            end
            if (wr) begin
                case (addr)
                    `OFS_PAGE: begin
                        page_reg <= wdata[7:0];
                    end
                    `OFS_EA: begin
                        if (state_reg == ST_IDLE) begin
                            ea_reg <= wdata[15:0];
                        end
                    end
                    `OFS_WDATA: begin
                        if (state_reg == ST_IDLE) begin
                            wdat_reg <= wdata[15:0];
                        end
                    end
                    `OFS_CMD: begin
                        if (state_reg == ST_IDLE) begin
                            cmd_reg <= wdata[3:0];
                        end
                    end
                    `OFS_WIN_PAGE: begin
                        win_page_reg <= wdata[7:0];
                    end
                    default: begin
                        page_reg <= page_reg;
                    end
                endcase
            end
        end
    end

    // -------------------------------------------------------------
    // program counter
    // -------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            pc_reg <= `RST_PC;
        end else if (ce && wr) begin
            if (addr == `OFS_PC) begin
                pc_reg <= align_addr(wdata[23:0]);
            end else if (addr == `OFS_PC_STEP) begin
                pc_reg <= next_word_addr(pc_reg);
            end
        end
    end

    // -------------------------------------------------------------
    // read port
    // -------------------------------------------------------------
    always @(posedge mclk) begin
        if (rst) begin
            rdata <= 32'h00000000;
        end else if (ce) begin
            rdata <= 32'h00000000;
            if (rd) begin
                case (addr)
                    `OFS_PAGE:     rdata <= {24'h000000, page_reg};
                    `OFS_EA:       rdata <= {16'h0000, ea_reg};
                    `OFS_WDATA:    rdata <= {16'h0000, wdat_reg};
                    `OFS_CMD:      rdata <= {28'h0000000, cmd_reg};
                    `OFS_RESULT:   rdata <= {16'h0000, result_reg};
                    `OFS_STATUS:   rdata <= {29'h0000000, cfg_reg,
                                             busy, done_reg};
                    `OFS_PADDR:    rdata <= {8'h00, paddr_reg};
                    `OFS_PC:       rdata <= {8'h00, pc_reg};
                    `OFS_WIN_PAGE: rdata <= {24'h000000, win_page_reg};
                    default:       rdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule // program_space_table_access

`default_nettype wire

// >>> verification/core_master_model.sv
// register master standing in for the core: one-cycle strobes
// assumes the slave never stalls and read data follow one cycle later
`timescale 1ns/1ps
`default_nettype none

module core_master_model (
    // clock
    input  wire logic        mclk,
    // register port
    output logic      [7:0]  addr,
    output logic      [31:0] wdata,
    output logic             wr,
    output logic             rd,
    input  wire logic [31:0] rdata
);
    initial begin
        addr = 8'h00;
        wdata = 32'h00000000;
        wr = 1'b0;
        rd = 1'b0;
    end

    // released qualifiers show the inverse, never the last value
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        @(posedge mclk);
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        addr <= ~a;
        @(posedge mclk);
        d = rdata;
    endtask
endmodule // core_master_model

`default_nettype wire

// >>> verification/pst_checker_properties.sv
// checker for the table access block: bus timing and result shaping
// assumes ce stays high while traffic is checked
`timescale 1ns/1ps
`default_nettype none
`include "pst_defs.vh"

module pst_checker (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic [31:0] rdata,
    input  wire logic        busy
);
    // ---------------------------------------------------------------
    // shadow of the last accepted command
    // ---------------------------------------------------------------
    logic [3:0] op_reg;
    logic       ea0_reg;
    logic       bsel_reg;
    logic       page7_reg;
    logic       cfg_reg;
    wire  logic rd_res;
    assign rd_res = rd && addr == `OFS_RESULT && !busy;

    always @(posedge mclk) begin
        if (rst) begin
            op_reg <= 4'h0;
            ea0_reg <= 1'b0;
            bsel_reg <= 1'b0;
            page7_reg <= 1'b0;
            cfg_reg <= 1'b0;
        end else if (ce && wr) begin
            if (addr == `OFS_PAGE)
                page7_reg <= wdata[7];
            if (addr == `OFS_EA && !busy)
                ea0_reg <= wdata[0];
            if (addr == `OFS_CMD && !busy) begin
                op_reg <= wdata[3:0];
                bsel_reg <= ea0_reg;
                cfg_reg <= page7_reg;
            end
        end
    end

    // ---------------------------------------------------------------
    // properties
    // ---------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst || !ce);

    sequence cmd_take;
        wr && addr == `OFS_CMD && !busy;
    endsequence
    sequence run_span;
        busy [*2] ##1 !busy;
    endsequence

    idle_rdata_zero_a: assert property (
        !rd |=> rdata == 32'h00000000)
        else $error("read data not zero outside a read");
    cmd_busy_span_a: assert property (cmd_take |=> run_span)
        else $error("command busy span wrong");
    status_busy_a: assert property (
        rd && addr == `OFS_STATUS |=> rdata[1] == $past(busy))
        else $error("status busy bit wrong");
    paddr_align_a: assert property (rd && addr == `OFS_PADDR |=>
        rdata[0] == 1'b0 && rdata[31:24] == 8'h00)
        else $error("program address not aligned");
    pc_align_a: assert property (rd && addr == `OFS_PC |=>
        rdata[0] == 1'b0 && rdata[31:24] == 8'h00)
        else $error("program counter not aligned");
    result_width_a: assert property (
        rd && addr == `OFS_RESULT |=> rdata[31:16] == 16'h0000)
        else $error("result wider than data word");
    high_word_zero_a: assert property (
        rd_res && op_reg == 4'h1 |=> rdata[15:8] == 8'h00)
        else $error("high word upper byte not zero");
    phantom_zero_a: assert property (
        rd_res && op_reg == 4'h9 && bsel_reg |=> rdata == 32'h00000000)
        else $error("phantom byte not zero");
    low_byte_zero_a: assert property (
        rd_res && op_reg == 4'h8 |=> rdata[15:8] == 8'h00)
        else $error("byte read upper byte not zero");
    cfg_flag_a: assert property (
        rd && addr == `OFS_STATUS && !busy && op_reg[2:0] != 3'h4 |=>
        rdata[2] == cfg_reg)
        else $error("space flag differs from page top bit");
endmodule // pst_checker

bind program_space_table_access pst_checker chk_i (
    .mclk(mclk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .busy(busy)
);

`default_nettype wire

// >>> verification/test_program_space_table_access.sv
// testbench for the table access block, driven through the core model
// assumes the register map and command walk of the block's hand-over
`timescale 1ns/1ps
`default_nettype none
`include "pst_defs.vh"

module test_program_space_table_access;
    logic        mclk;
    logic        rst;
    logic        ce;
    wire  [7:0]  addr;
    wire  [31:0] wdata;
    wire         wr;
    wire         rd;
    wire  [31:0] rdata;
    wire         busy;
    int          error_cnt;
    int          checked;
    logic [31:0] v;

    always #25 mclk = ~mclk;

    core_master_model m (.mclk(mclk), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata));
    program_space_table_access uut (.mclk(mclk), .rst(rst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .busy(busy));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
                        input string nm);
        m.reg_read(a, v);
        chk(nm, v, exp);
    endtask

    task automatic tbl(input logic [15:0] ea, input logic [3:0] cmd,
                       input logic [31:0] wd);
        int n;
        m.reg_write(`OFS_EA, {16'h0000, ea});
        m.reg_write(`OFS_WDATA, wd);
        m.reg_write(`OFS_CMD, {28'h0000000, cmd});
        n = 0;
        while (busy !== 1'b0 && n < 10) begin
            @(posedge mclk);
            n++;
        end
        chk("busy", {31'h0, busy}, 32'h0);
    endtask

    task automatic print_verdict;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ---------------------------------------------------------------
    // watchdog
    // ---------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        print_verdict;
    end

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        error_cnt = 0;
        checked = 0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rchk(`OFS_PAGE, 32'h0, "page");
        rchk(`OFS_PC, 32'h0, "pc");
        rchk(`OFS_STATUS, 32'h0, "status");
        rchk(8'h28, 32'h0, "unmapped");
        tbl(16'h0010, 4'h2, 32'h0000ABCD);
        tbl(16'h0010, 4'h3, 32'h0000005A);
        tbl(16'h0011, 4'h0, 32'h0);
        rchk(`OFS_RESULT, 32'hABCD, "low word");
        tbl(16'h0010, 4'h5, 32'h0);
        rchk(`OFS_RESULT, 32'hABCD, "no-op result");
        tbl(16'h0010, 4'h1, 32'h0);
        rchk(`OFS_RESULT, 32'h005A, "high word");
        tbl(16'h0010, 4'h8, 32'h0);
        rchk(`OFS_RESULT, 32'h00CD, "low byte 0");
        tbl(16'h0011, 4'h8, 32'h0);
        rchk(`OFS_RESULT, 32'h00AB, "low byte 1");
        tbl(16'h0010, 4'h9, 32'h0);
        rchk(`OFS_RESULT, 32'h005A, "high byte 0");
        tbl(16'h0011, 4'h9, 32'h0);
        rchk(`OFS_RESULT, 32'h0, "phantom");
        rchk(`OFS_PADDR, 32'h10, "paddr odd ea");
        rchk(`OFS_STATUS, 32'h1, "done");
        m.reg_write(`OFS_STATUS, 32'h1);
        rchk(`OFS_STATUS, 32'h0, "done clear");
        tbl(16'h0011, 4'hA, 32'h00000077);
        tbl(16'h0011, 4'hB, 32'h00000011);
        tbl(16'h0010, 4'h0, 32'h0);
        rchk(`OFS_RESULT, 32'h77CD, "byte write");
        tbl(16'h0010, 4'h1, 32'h0);
        rchk(`OFS_RESULT, 32'h005A, "phantom write");
        m.reg_write(`OFS_PAGE, 32'h81);
        tbl(16'h0010, 4'h2, 32'h00001234);
        tbl(16'h0010, 4'h0, 32'h0);
        rchk(`OFS_RESULT, 32'h1234, "cfg read");
        rchk(`OFS_PADDR, 32'h810010, "cfg paddr");
        rchk(`OFS_STATUS, 32'h5, "cfg flag");
        m.reg_write(`OFS_PAGE, 32'h0);
        tbl(16'h0010, 4'h0, 32'h0);
        rchk(`OFS_RESULT, 32'h77CD, "user read");
        m.reg_write(`OFS_WIN_PAGE, 32'h0);
        tbl(16'h8010, 4'h4, 32'h0);
        rchk(`OFS_RESULT, 32'h77CD, "window");
        m.reg_write(`OFS_PC, 32'h5);
        rchk(`OFS_PC, 32'h4, "pc load");
        m.reg_write(`OFS_PC_STEP, 32'h0);
        rchk(`OFS_PC, 32'h6, "pc step");
        ce <= 1'b0;
        m.reg_write(`OFS_PC_STEP, 32'h0);
        ce <= 1'b1;
        rchk(`OFS_PC, 32'h6, "pc frozen");
        m.reg_write(`OFS_EA, 32'h20);
        m.reg_write(`OFS_CMD, 32'h0);
        m.reg_write(`OFS_EA, 32'h30);
        rchk(`OFS_EA, 32'h20, "ea while busy");
        m.reg_write(`OFS_CMD, 32'h5);
        m.reg_read(`OFS_STATUS, v);
        chk("busy bit", {31'h0, v[1]}, 32'h1);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rchk(`OFS_EA, 32'h0, "ea after reset");
        rchk(`OFS_PC, 32'h0, "pc after reset");
        rchk(`OFS_STATUS, 32'h0, "status after reset");
        rchk(`OFS_RESULT, 32'h0, "result after reset");
        print_verdict;
    end
endmodule // test_program_space_table_access

`default_nettype wire
